// ===== design/odd_axis_classifier.sv
`timescale 1ns/10ps
// ==================================================
// Per-axis comparison against the orientation threshold
module odd_axis_classifier (
  input wire logic signed [15:0] sample_i,
  input wire logic [15:0] thr_i,
  output logic above_o,
  output logic below_o,
  output logic high_o,
  output logic low_o
);

  logic [16:0] mag; // Extra bit keeps the most negative value exact

  // Magnitude and sign split
  always_comb begin
    if (sample_i[15]) begin
      mag = 17'(-$signed({sample_i[15], sample_i}));
    end else begin
      mag = {1'b0, sample_i};
    end
    above_o = mag > {1'b0, thr_i};
    below_o = mag < {1'b0, thr_i};
    high_o = above_o && !sample_i[15];
    low_o = above_o && sample_i[15];
  end

endmodule : odd_axis_classifier

// ===== design/odd_detector.sv
`timescale 1ns/10ps
module odd_detector (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic soft_reset_i,
  input wire logic [1:0] full_scale_i,
  input wire logic data_enable_ready_i,
  input wire logic sample_valid_i,
  input wire odd_pkg::odd_sample_s raw_sample_i,
  input wire odd_pkg::odd_sample_s second_lowpass_stage_sample_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_pin_one_o,
  output logic irq_pin_two_o
);

  // ==================================================
  // State
  odd_pkg::odd_state_s state_reg; // All block state
  odd_pkg::odd_state_s state_next; // Its next value

  // Combinational helpers, all from state_reg and inputs
  odd_pkg::odd_sample_s sel_sample; // Detector input after filter select
  logic [15:0] sin_q15;             // Chosen angle, Q15
  logic [15:0] thr;                 // Threshold in sample counts
  logic [2:0] above;                // Per axis, index 0 = x
  logic [2:0] below;
  logic [2:0] high;
  logic [2:0] low;
  logic four_dir;                   // Z axis excluded
  logic [5:0] flags;                // {zh,zl,yh,yl,xh,xl}
  logic ok_now;                     // This sample holds one orientation
  logic confirmed;                  // Same orientation two samples running
  logic new_pos;                    // Orientation differs from last report
  logic latched_mode;               // Latch really in effect
  logic src_read;                   // Read of either source register

  // ==================================================
  // Input selection and threshold
  // Config comes from the registered copy, so a write
  // only affects samples taken after it has landed
  always_comb begin
    if (state_reg.cfg.filter[odd_pkg::LOWPASS_BIT]) begin
      sel_sample = second_lowpass_stage_sample_i;
    end else begin
      sel_sample = raw_sample_i;
    end
    // Angle table; same angle at any full scale
    case (state_reg.cfg.threshold[odd_pkg::ANGLE_LSB +: 2])
      2'h0: sin_q15 = odd_pkg::SIN_Q15_80;
      2'h1: sin_q15 = odd_pkg::SIN_Q15_70;
      2'h2: sin_q15 = odd_pkg::SIN_Q15_60;
      default: sin_q15 = odd_pkg::SIN_Q15_50;
    endcase
    // One g halves per full scale step, so the shift tracks it
    thr = sin_q15 >> (odd_pkg::FS_BASE_SHIFT + {3'h0, full_scale_i});
  end

  // ==================================================
  // Axis classifiers, one per axis
  // Three equal comparators; z is masked later, so the
  // four-direction mode costs no extra compare logic
  for (genvar g = 0; g < 3; g++) begin : g_axis
    logic signed [15:0] axis_val; // This axis of the selected sample
    assign axis_val = (g == 0) ? sel_sample.x : ((g == 1) ? sel_sample.y : sel_sample.z);
    odd_axis_classifier u_axis (
      .sample_i(axis_val),
      .thr_i(thr),
      .above_o(above[g]),
      .below_o(below[g]),
      .high_o(high[g]),
      .low_o(low[g])
    );
  end

  // ==================================================
  // Orientation recognition
  // Equal to the threshold is neither above nor below, so a
  // sample sitting on the angle never yields an orientation
  always_comb begin
    four_dir = state_reg.cfg.threshold[odd_pkg::FOUR_DIR_BIT];
    // Z flags masked in four-direction mode
    flags = {high[2] && !four_dir, low[2] && !four_dir,
             high[1], low[1], high[0], low[0]};
    // Four-direction mode ignores the z axis entirely
    if (four_dir) begin
      ok_now = (above[0] && below[1]) || (above[1] && below[0]);
    end else begin
      ok_now = (above[0] && below[1] && below[2])
             || (above[1] && below[0] && below[2])
             || (above[2] && below[0] && below[1]);
    end
    // Must match the candidate held from the previous sample
    confirmed = ok_now && state_reg.cand_ok && (flags == state_reg.cand);
    new_pos = sample_valid_i && confirmed && (flags != state_reg.last_pos);
    // Latch only counts when some pin carries the event
    latched_mode = state_reg.cfg.irq_config[odd_pkg::LATCH_BIT]
                 && (state_reg.cfg.pin1[odd_pkg::ROUTE_BIT]
                 || state_reg.cfg.pin2[odd_pkg::ROUTE_BIT]);
    // Either source register clears a latched request
    src_read = reg_rd_i && ((reg_addr_i == odd_pkg::ADDR_ORIENT_SRC)
             || (reg_addr_i == odd_pkg::ADDR_COMBINED_SRC));
  end

  // ==================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    // Priority: writes, soft reset, reads, latch, sample
    // Later branches override earlier ones
    // Register writes
    // Source registers are read-only; writes fall to default
    if (reg_wr_i) begin
      case (reg_addr_i)
        odd_pkg::ADDR_IRQ_CONFIG: state_next.cfg.irq_config = reg_wdata_i;
        odd_pkg::ADDR_IRQ_ENABLE: state_next.cfg.irq_enable = reg_wdata_i;
        odd_pkg::ADDR_THRESHOLD: state_next.cfg.threshold = reg_wdata_i;
        odd_pkg::ADDR_FILTER_CTRL: state_next.cfg.filter = reg_wdata_i;
        odd_pkg::ADDR_PIN1_ROUTE: state_next.cfg.pin1 = reg_wdata_i;
        odd_pkg::ADDR_PIN2_ROUTE: state_next.cfg.pin2 = reg_wdata_i;
        default: state_next.cfg = state_next.cfg; // Unmapped or read-only
      endcase
    end
    // Software reset beats a write in the same cycle
    // Detection state is kept; only config bytes return
    if (soft_reset_i) begin
      state_next.cfg = odd_pkg::CFG_RESET;
    end
    // Register reads; data lands one cycle later
    if (reg_rd_i) begin
      case (reg_addr_i)
        odd_pkg::ADDR_ORIENT_SRC: begin
          state_next.rdata = {data_enable_ready_i,
                              state_reg.ev != odd_pkg::ODD_EV_IDLE,
                              state_reg.pos};
        end
        odd_pkg::ADDR_COMBINED_SRC: begin
          state_next.rdata = odd_pkg::RDATA_RESET;
          state_next.rdata[odd_pkg::COMB_ORIENT_BIT] = state_reg.ev != odd_pkg::ODD_EV_IDLE;
        end
        // Config bytes read back as written
        odd_pkg::ADDR_IRQ_CONFIG: state_next.rdata = state_reg.cfg.irq_config;
        odd_pkg::ADDR_IRQ_ENABLE: state_next.rdata = state_reg.cfg.irq_enable;
        odd_pkg::ADDR_THRESHOLD: state_next.rdata = state_reg.cfg.threshold;
        odd_pkg::ADDR_FILTER_CTRL: state_next.rdata = state_reg.cfg.filter;
        odd_pkg::ADDR_PIN1_ROUTE: state_next.rdata = state_reg.cfg.pin1;
        odd_pkg::ADDR_PIN2_ROUTE: state_next.rdata = state_reg.cfg.pin2;
        default: state_next.rdata = odd_pkg::RDATA_RESET; // Unmapped reads zero
      endcase
    end
    // Latch dropped while pending: finish as a pulse
    if (state_reg.ev == odd_pkg::ODD_EV_LATCHED && !latched_mode) begin
      state_next.ev = odd_pkg::ODD_EV_PULSE;
    end
    // Read clears a latched request and re-arms detection
    // A pulse is left alone; it ends at the next sample
    if (src_read && state_reg.ev == odd_pkg::ODD_EV_LATCHED) begin
      state_next.ev = odd_pkg::ODD_EV_IDLE;
    end
    // Sample boundary
    // An unconfirmed sample clears the flags, so they show
    // the current state only, never a stale orientation
    if (sample_valid_i) begin
      state_next.cand = ok_now ? flags : odd_pkg::FLAGS_RESET;
      state_next.cand_ok = ok_now;
      state_next.pos = confirmed ? flags : odd_pkg::FLAGS_RESET;
      // Pulse ends after one output period
      if (state_next.ev == odd_pkg::ODD_EV_PULSE) begin
        state_next.ev = odd_pkg::ODD_EV_IDLE;
      end
      // New orientation; set wins over a clear in the same cycle
      // A waiting latched request hides new orientations
      if (new_pos && state_next.ev != odd_pkg::ODD_EV_LATCHED) begin
        state_next.ev = latched_mode ? odd_pkg::ODD_EV_LATCHED
                                     : odd_pkg::ODD_EV_PULSE;
        state_next.last_pos = flags;
      end
    end
    // Pins follow the flag, gated by enable and routing
    // Built from next values, so pins move with the flag
    state_next.pin1 = state_next.cfg.irq_enable[odd_pkg::IRQ_EN_BIT]
                    && state_next.cfg.pin1[odd_pkg::ROUTE_BIT]
                    && state_next.ev != odd_pkg::ODD_EV_IDLE;
    state_next.pin2 = state_next.cfg.irq_enable[odd_pkg::IRQ_EN_BIT]
                    && state_next.cfg.pin2[odd_pkg::ROUTE_BIT]
                    && state_next.ev != odd_pkg::ODD_EV_IDLE;
  end

  // ==================================================
  // State register
  // Synchronous reset; pattern follows the struct order
  // Event and flags start idle, config at defaults
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg <= '{odd_pkg::CFG_RESET, odd_pkg::FLAGS_RESET, 1'b0,
                     odd_pkg::FLAGS_RESET, odd_pkg::FLAGS_RESET,
                     odd_pkg::ODD_EV_IDLE, 1'b0, 1'b0, odd_pkg::RDATA_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  // No logic after the flops, so the pins are glitch free
  // The host sees no combinational path from its strobes
  assign reg_rdata_o = state_reg.rdata;
  assign irq_pin_one_o = state_reg.pin1;
  assign irq_pin_two_o = state_reg.pin2;

  // ==================================================
  // Checks
  // All checks share the one clock and sleep in reset
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // Pins never rise without the global enable
  a_pin_needs_enable: assert property ((irq_pin_one_o || irq_pin_two_o)
    |-> state_reg.cfg.irq_enable[odd_pkg::IRQ_EN_BIT])
    else $error("pin high without global enable");
  // Each pin needs its own route bit and a pending event
  a_pin_one_route: assert property (irq_pin_one_o
    |-> state_reg.cfg.pin1[odd_pkg::ROUTE_BIT] && state_reg.ev != odd_pkg::ODD_EV_IDLE)
    else $error("pin one high without route or event");
  a_pin_two_route: assert property (irq_pin_two_o
    |-> state_reg.cfg.pin2[odd_pkg::ROUTE_BIT] && state_reg.ev != odd_pkg::ODD_EV_IDLE)
    else $error("pin two high without route or event");
  // An unlatched event ends at the next sample
  a_pulse_one_period: assert property (state_reg.ev == odd_pkg::ODD_EV_PULSE
    && sample_valid_i && !new_pos |=> state_reg.ev == odd_pkg::ODD_EV_IDLE)
    else $error("pulse outlived its output period");
  // A latched event waits for the host
  a_latch_holds: assert property (state_reg.ev == odd_pkg::ODD_EV_LATCHED && latched_mode
    && !src_read && !reg_wr_i && !soft_reset_i |=> state_reg.ev == odd_pkg::ODD_EV_LATCHED)
    else $error("latched event dropped without a read");
  // The clearing read returns a latched event to idle
  a_read_clears: assert property (state_reg.ev == odd_pkg::ODD_EV_LATCHED && src_read
    && !new_pos |=> state_reg.ev == odd_pkg::ODD_EV_IDLE)
    else $error("source read did not clear latched event");
  // At most one direction flag at a time
  a_flags_onehot: assert property ($onehot0(state_reg.pos))
    else $error("more than one axis flag set");
  // Four-direction mode never reports z
  a_four_dir_noz: assert property (sample_valid_i && four_dir
    |=> state_reg.pos[5:4] == 2'h0)
    else $error("z flag set in four-direction mode");
  // A held orientation raises no second event
  a_no_repeat_event: assert property (sample_valid_i && confirmed
    && flags == state_reg.last_pos |=> state_reg.ev != odd_pkg::ODD_EV_PULSE)
    else $error("event repeated for unchanged orientation");
  // An event only starts with a new, different orientation
  a_event_on_change: assert property (state_reg.ev == odd_pkg::ODD_EV_IDLE
    ##1 state_reg.ev != odd_pkg::ODD_EV_IDLE
    |-> state_reg.pos != odd_pkg::FLAGS_RESET && state_reg.pos == state_reg.last_pos
    && state_reg.pos != $past(state_reg.last_pos))
    else $error("event without a change of orientation");
  // Flags come from two matching samples
  a_two_samples: assert property (state_reg.pos != odd_pkg::FLAGS_RESET
    |-> state_reg.cand_ok && state_reg.cand == state_reg.pos)
    else $error("orientation taken from a single sample");
  // Flags and candidate move only on a sample boundary
  a_flags_on_sample: assert property (!sample_valid_i
    |=> $stable(state_reg.pos) && $stable(state_reg.cand))
    else $error("direction flags moved between samples");
  // Source byte: ready, event, then the six flags
  a_src_fields: assert property (reg_rd_i && reg_addr_i == odd_pkg::ADDR_ORIENT_SRC
    |=> reg_rdata_o[odd_pkg::SRC_DRDY_BIT] == $past(data_enable_ready_i)
    && reg_rdata_o[odd_pkg::SRC_EVENT_BIT] == ($past(state_reg.ev) != odd_pkg::ODD_EV_IDLE)
    && reg_rdata_o[5:0] == $past(state_reg.pos))
    else $error("source register fields out of place");
  // A latch with no route decays like a pulse
  a_unrouted_latch: assert property (state_reg.ev == odd_pkg::ODD_EV_LATCHED
    && !latched_mode && !reg_wr_i && !soft_reset_i
    |=> state_reg.ev != odd_pkg::ODD_EV_LATCHED)
    else $error("latch held though event routed nowhere");
  // Software reset restores every configuration byte
  a_soft_reset_cfg: assert property (soft_reset_i |=> state_reg.cfg == odd_pkg::CFG_RESET)
    else $error("software reset left configuration");

  // Main scenarios the bench should reach
  c_pulse_event: cover property (state_reg.ev == odd_pkg::ODD_EV_PULSE && irq_pin_one_o);
  c_latched_event: cover property (state_reg.ev == odd_pkg::ODD_EV_LATCHED ##1 src_read);
  c_four_dir_event: cover property (four_dir && new_pos);
  c_set_beats_clear: cover property (src_read && new_pos);
  c_latch_dropped: cover property (state_reg.ev == odd_pkg::ODD_EV_LATCHED && !latched_mode);

endmodule : odd_detector

// ===== design/odd_pkg.sv
// ==================================================
// Orientation detector shared definitions
package odd_pkg;

  // ==================================================
  // Widths
  localparam int ADDR_W = 8;   // Register address width
  localparam int DATA_W = 8;   // Register data width
  localparam int SAMP_W = 16;  // Accelerometer sample width

  // ==================================================
  // Register addresses
  localparam logic [7:0] ADDR_FILTER_CTRL = 8'h17;  // accel_filter_control
  localparam logic [7:0] ADDR_COMBINED_SRC = 8'h1A; // combined_irq_source
  localparam logic [7:0] ADDR_ORIENT_SRC = 8'h1D;   // orientation_source
  localparam logic [7:0] ADDR_IRQ_CONFIG = 8'h56;   // irq_config_reg
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h58;   // irq_enable_reg
  localparam logic [7:0] ADDR_THRESHOLD = 8'h59;    // orientation_threshold_reg
  localparam logic [7:0] ADDR_PIN1_ROUTE = 8'h5E;   // pin1_routing_reg
  localparam logic [7:0] ADDR_PIN2_ROUTE = 8'h5F;   // pin2_routing_reg

  // ==================================================
  // Field positions
  localparam int LATCH_BIT = 0;       // latch_select in irq_config_reg
  localparam int IRQ_EN_BIT = 7;      // Global enable in irq_enable_reg
  localparam int ROUTE_BIT = 2;       // Orientation route in pin routing regs
  localparam int ANGLE_LSB = 5;       // orientation_angle_select low bit
  localparam int FOUR_DIR_BIT = 7;    // four_direction_enable
  localparam int LOWPASS_BIT = 0;     // orientation_lowpass_select
  localparam int SRC_DRDY_BIT = 7;    // data_enable_ready in source reg
  localparam int SRC_EVENT_BIT = 6;   // orientation_event_flag in source reg
  localparam int COMB_ORIENT_BIT = 4; // Orientation event in combined source

  // ==================================================
  // Reset values
  localparam logic [7:0] CFG_BYTE_RESET = 8'h00;  // Every config byte
  localparam logic [5:0] FLAGS_RESET = 6'h00;     // No orientation known
  localparam logic [7:0] RDATA_RESET = 8'h00;     // Read data idle

  // ==================================================
  // Sine of threshold angle, Q15; code 00..11 = 80,70,60,50 degrees
  localparam logic [15:0] SIN_Q15_80 = 16'h7E0E;
  localparam logic [15:0] SIN_Q15_70 = 16'h7848;
  localparam logic [15:0] SIN_Q15_60 = 16'h6EDA;
  localparam logic [15:0] SIN_Q15_50 = 16'h620E;
  // Shift from Q15 to 1 g counts at the smallest full scale
  localparam logic [4:0] FS_BASE_SHIFT = 5'h01;

  // ==================================================
  // Types
  typedef enum logic [1:0] {
    ODD_EV_IDLE,
    ODD_EV_PULSE,
    ODD_EV_LATCHED
  } odd_event_e;

  typedef struct packed {
    logic [7:0] irq_config;
    logic [7:0] irq_enable;
    logic [7:0] threshold;
    logic [7:0] filter;
    logic [7:0] pin1;
    logic [7:0] pin2;
  } odd_cfg_s;

  localparam odd_cfg_s CFG_RESET = '{CFG_BYTE_RESET, CFG_BYTE_RESET,
                                     CFG_BYTE_RESET, CFG_BYTE_RESET,
                                     CFG_BYTE_RESET, CFG_BYTE_RESET};

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } odd_sample_s;

  typedef struct packed {
    odd_cfg_s cfg;        // Configuration registers
    logic [5:0] cand;     // Candidate from the previous sample
    logic cand_ok;        // Previous sample held a valid candidate
    logic [5:0] pos;      // Current direction flags
    logic [5:0] last_pos; // Last reported orientation
    odd_event_e ev;       // Event flag state
    logic pin1;           // First interrupt pin
    logic pin2;           // Second interrupt pin
    logic [7:0] rdata;    // Read data
  } odd_state_s;

endpackage : odd_pkg

// ===== test/odd_host_model.sv
`timescale 1ns/10ps
// ==================================================
// Host processor on the register strobes
module odd_host_model (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  // Idle bus at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One write; address and data scrambled once the strobe is gone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clock_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  // One read; data is registered, so it is taken after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(posedge clock_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask : rd

  // Latched orientation on pin one; threshold and filter set after enable
  task automatic setup_latched(input logic [7:0] thr, input logic [7:0] filt);
    wr(odd_pkg::ADDR_IRQ_CONFIG, 8'h41);
    wr(odd_pkg::ADDR_IRQ_ENABLE, 8'h80);
    wr(odd_pkg::ADDR_THRESHOLD, thr);
    wr(odd_pkg::ADDR_FILTER_CTRL, filt);
    wr(odd_pkg::ADDR_PIN1_ROUTE, 8'h04);
  endtask : setup_latched
endmodule : odd_host_model

// ===== test/orientation_6d_4d_detector_tb_top.sv
`timescale 1ns/10ps
// ==================================================
// Self-checking bench for the orientation detector
module orientation_6d_4d_detector_tb_top;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [5:0] flags; // Expected {zh,zl,yh,yl,xh,xl}
  } odd_row_s;
  localparam logic [15:0] GP = 16'h4000; // +1 g at 2 g scale
  localparam logic [15:0] GN = 16'hC000; // -1 g at 2 g scale
  logic clock, resetn, soft_reset, den_ready, sample_valid;
  logic [1:0] full_scale;
  odd_pkg::odd_sample_s raw_sample, second_lowpass_stage_sample;
  logic reg_wr, reg_rd, pin_one, pin_two;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdata;
  logic [15:0] thr;
  int failures, num_checks;
  // Each row differs from the one before, so each is a new orientation
  odd_row_s rows [6] = '{'{16'h0, GP, 16'h0, 6'h08}, '{GN, 16'h0, 16'h0, 6'h01},
    '{GP, 16'h0, 16'h0, 6'h02}, '{16'h0, GN, 16'h0, 6'h04},
    '{16'h0, 16'h0, GP, 6'h20}, '{16'h0, 16'h0, GN, 6'h10}};
  logic [15:0] sin_tbl [4] = '{odd_pkg::SIN_Q15_80, odd_pkg::SIN_Q15_70,
    odd_pkg::SIN_Q15_60, odd_pkg::SIN_Q15_50};

  // ==================================================
  // Design and host
  odd_detector i_dut (.clock_i(clock), .resetn_i(resetn), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .soft_reset_i(soft_reset), .full_scale_i(full_scale),
    .data_enable_ready_i(den_ready), .sample_valid_i(sample_valid),
    .raw_sample_i(raw_sample), .second_lowpass_stage_sample_i(second_lowpass_stage_sample),
    .reg_rdata_o(reg_rdata), .irq_pin_one_o(pin_one), .irq_pin_two_o(pin_two));
  odd_host_model i_host (.clock_i(clock), .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

  // ==================================================
  // Helpers
  function automatic odd_pkg::odd_sample_s smp(input logic [15:0] x, y, z);
    smp = {x, y, z};
  endfunction : smp
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_pin(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin
  // One sample; inputs scrambled afterwards, so only the strobe may count
  task automatic send(input odd_pkg::odd_sample_s r, input odd_pkg::odd_sample_s l);
    @(posedge clock);
    #1;
    sample_valid = 1'b1;
    raw_sample = r;
    second_lowpass_stage_sample = l;
    @(posedge clock);
    #1;
    sample_valid = 1'b0;
    raw_sample = ~r;
    second_lowpass_stage_sample = ~l;
  endtask : send
  // Two equal samples confirm an orientation
  task automatic send2(input odd_pkg::odd_sample_s s);
    send(s, s);
    send(s, s);
  endtask : send2
  task automatic src_flags(input logic [5:0] e);
    i_host.rd(odd_pkg::ADDR_ORIENT_SRC, rdata);
    chk_byte("axis flags", {2'b00, e}, rdata & 8'h3F);
  endtask : src_flags
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ==================================================
  // Clock and watchdog; the tests need a few hundred cycles
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #500000;
    failures++;
    report_and_stop();
  end

  // ==================================================
  // Main sequence
  initial begin
    {resetn, soft_reset, den_ready, sample_valid, full_scale} = '0;
    raw_sample = '0;
    second_lowpass_stage_sample = '0;
    failures = 0;
    num_checks = 0;
    repeat (16) @(posedge clock);
    #1;
    resetn = 1'b1;
    i_host.rd(odd_pkg::ADDR_IRQ_CONFIG, rdata);
    chk_byte("config after reset", odd_pkg::CFG_BYTE_RESET, rdata);
    i_host.setup_latched(8'h00, 8'h00);
    // Six orientations, latched on pin one, cleared by reading the source
    foreach (rows[i]) begin
      send2(smp(rows[i].x, rows[i].y, rows[i].z));
      chk_pin("pin one latched", 1'b1, pin_one);
      i_host.rd(odd_pkg::ADDR_ORIENT_SRC, rdata);
      chk_byte("source", {2'b01, rows[i].flags}, rdata);
      @(posedge clock);
      #1;
      chk_pin("pin one cleared", 1'b0, pin_one);
    end
    // Same orientation kept: no new event, flags still current
    send2(smp(16'h0, 16'h0, GN));
    chk_pin("pin one held", 1'b0, pin_one);
    den_ready = 1'b1;
    i_host.rd(odd_pkg::ADDR_ORIENT_SRC, rdata);
    chk_byte("source kept", 8'h90, rdata);
    // Clearing through the combined source
    send2(smp(GP, 16'h0, 16'h0));
    i_host.rd(odd_pkg::ADDR_COMBINED_SRC, rdata);
    chk_byte("combined", 8'h01 << odd_pkg::COMB_ORIENT_BIT, rdata);
    @(posedge clock);
    #1;
    chk_pin("pin one combined", 1'b0, pin_one);
    // Route removed while a latched event waits: it decays as a pulse
    send2(smp(16'h0, 16'h0, GP));
    chk_pin("pin one before unroute", 1'b1, pin_one);
    i_host.wr(odd_pkg::ADDR_PIN1_ROUTE, 8'h00);
    chk_pin("pin one unrouted latch", 1'b0, pin_one);
    send(smp(16'h0, 16'h0, GP), smp(16'h0, 16'h0, GP));
    i_host.rd(odd_pkg::ADDR_ORIENT_SRC, rdata);
    chk_byte("unrouted latch source", 8'hA0, rdata);
    i_host.wr(odd_pkg::ADDR_PIN1_ROUTE, 8'h04);
    // Pulsed mode: one output period only
    i_host.wr(odd_pkg::ADDR_IRQ_CONFIG, 8'h00);
    send2(smp(16'h0, GN, 16'h0));
    chk_pin("pin one pulse", 1'b1, pin_one);
    send(smp(16'h0, GN, 16'h0), smp(16'h0, GN, 16'h0));
    chk_pin("pin one pulse end", 1'b0, pin_one);
    i_host.rd(odd_pkg::ADDR_ORIENT_SRC, rdata);
    chk_byte("pulse source", 8'h84, rdata);
    // Latch without any route acts as pulsed
    i_host.wr(odd_pkg::ADDR_IRQ_CONFIG, 8'h41);
    i_host.wr(odd_pkg::ADDR_PIN1_ROUTE, 8'h00);
    send2(smp(16'h0, GP, 16'h0));
    chk_pin("pin one unrouted", 1'b0, pin_one);
    send(smp(16'h0, GP, 16'h0), smp(16'h0, GP, 16'h0));
    i_host.rd(odd_pkg::ADDR_ORIENT_SRC, rdata);
    chk_byte("unrouted source", 8'h88, rdata);
    // Global enable gates pin two; both pins rise once it is set
    i_host.wr(odd_pkg::ADDR_IRQ_CONFIG, 8'h00);
    i_host.wr(odd_pkg::ADDR_PIN1_ROUTE, 8'h04);
    i_host.wr(odd_pkg::ADDR_PIN2_ROUTE, 8'h04);
    i_host.wr(odd_pkg::ADDR_IRQ_ENABLE, 8'h00);
    send2(smp(GN, 16'h0, 16'h0));
    chk_pin("pin two disabled", 1'b0, pin_two);
    i_host.wr(odd_pkg::ADDR_IRQ_ENABLE, 8'h80);
    send2(smp(GP, 16'h0, 16'h0));
    chk_pin("pin one enabled", 1'b1, pin_one);
    chk_pin("pin two enabled", 1'b1, pin_two);
    // Two axes above: no orientation
    send2(smp(GP, GP, 16'h0));
    src_flags(6'h00);
    // Each angle code at its own full scale (code c with scale c); equal to threshold counts neither
    for (int c = 0; c < 4; c++) begin
      full_scale = 2'(c);
      i_host.wr(odd_pkg::ADDR_THRESHOLD, 8'(c) << odd_pkg::ANGLE_LSB);
      thr = sin_tbl[c] >> (odd_pkg::FS_BASE_SHIFT + 5'(c));
      send2(smp(thr + 16'h1, 16'h0, 16'h0));
      src_flags(6'h02);
      send2(smp(16'h0, ~thr, 16'h0));
      src_flags(6'h04);
      send2(smp(thr, 16'h0, 16'h0));
      src_flags(6'h00);
    end
    full_scale = 2'b00;
    i_host.wr(odd_pkg::ADDR_THRESHOLD, 8'h00);
    // Second lowpass stage feeds detection when selected
    i_host.wr(odd_pkg::ADDR_FILTER_CTRL, 8'h01);
    send(smp(GN, 16'h0, 16'h0), smp(16'h0, GP, 16'h0));
    send(smp(GN, 16'h0, 16'h0), smp(16'h0, GP, 16'h0));
    src_flags(6'h08);
    // Four-direction mode ignores z
    i_host.wr(odd_pkg::ADDR_THRESHOLD, 8'h80);
    send2(smp(16'h0, 16'h0, GP));
    src_flags(6'h00);
    send2(smp(GP, 16'h0, 16'h0));
    src_flags(6'h02);
    // Software reset restores configuration; unmapped read gives zero
    i_host.wr(odd_pkg::ADDR_IRQ_CONFIG, 8'h41);
    @(posedge clock);
    #1;
    soft_reset = 1'b1;
    @(posedge clock);
    #1;
    soft_reset = 1'b0;
    i_host.rd(odd_pkg::ADDR_IRQ_CONFIG, rdata);
    chk_byte("config soft reset", 8'h00, rdata);
    i_host.rd(odd_pkg::ADDR_THRESHOLD, rdata);
    chk_byte("threshold soft reset", 8'h00, rdata);
    i_host.rd(8'h00, rdata);
    chk_byte("unmapped", 8'h00, rdata);
    report_and_stop();
  end
endmodule : orientation_6d_4d_detector_tb_top
